// ===== core/sleep_clock_ctrl.sv
// Sleep-mode clock gating controller
// Summary of operation
// - Four software-selectable sleep modes
// - Idle stops core, keeps memory, timers, serial
// - Power-down keeps all register and memory contents
// - Power-down stops oscillator; interrupt or reset wakes
// - Power-save keeps asynchronous timer running
// - ADC quiet mode keeps only converter, main oscillator, async timer, interrupts
`timescale 1ns/1ps
`default_nettype none
module sleep_clock_ctrl
(
   input  wire logic                    CLK,
   input  wire logic                    RESET,
   input  wire logic                    SLEEP_ENABLE,
   input  wire logic [1:0]              MODE_SELECT,
   input  wire logic                    SLEEP_REQUEST,
   input  wire logic                    WAKE_IRQ,
   output var sleep_ctrl_pkg::clk_en_t  CLOCK_ENABLE,
   output logic                         ASLEEP,
   output logic [1:0]                   ACTIVE_MODE
);
   import sleep_ctrl_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic         irq_meta;
   logic         irq_sync;
   sleep_state_t state;
   sleep_state_t next_state;
   logic [1:0]   mode;
   logic [1:0]   next_mode;
   logic [1:0]   wake_cnt;
   logic [1:0]   next_wake_cnt;
   clk_en_t      sleep_en;
   clk_en_t      wake_en;
   clk_en_t      next_en;

   // ---------------------------------------------------------------
   // Input synchroniser for the wake interrupt (asynchronous source)
   // ---------------------------------------------------------------
   // Nothing but the second stage reads the first, which may be metastable
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         irq_meta <= 1'b0;
      end
      else
      begin
         irq_meta <= WAKE_IRQ;
      end
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         irq_sync <= 1'b0;
      end
      else
      begin
         irq_sync <= irq_meta;
      end
   end

   // ---------------------------------------------------------------
   // Request and wake decode
   // ---------------------------------------------------------------
   // A pending wake refuses entry, so an interrupt is never slept through
   wire running = (state == ST_RUN);
   wire waking  = (state == ST_WAKE);
   wire enter   = SLEEP_ENABLE & SLEEP_REQUEST & ~irq_sync;
   wire take    = running & enter;
   wire wake    = irq_sync;
   wire settled = (wake_cnt == WAKE_CYCLES);

   // ---------------------------------------------------------------
   // Mode latch
   // ---------------------------------------------------------------
   // Mode is latched at entry so a change during sleep has no effect
   assign next_mode = take ? MODE_SELECT : mode;

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         mode <= MODE_RESET;
      end
      else
      begin
         mode <= next_mode;
      end
   end

   // ---------------------------------------------------------------
   // Mode to clock-enable map
   // ---------------------------------------------------------------
   // The map reads the mode being latched, so the first sleep cycle is right
   sleep_gate_map u_map
   (
      .mode (next_mode),
      .en   (sleep_en)
   );

   // ---------------------------------------------------------------
   // State machine
   // ---------------------------------------------------------------
   // Only an interrupt or a hardware reset leaves sleep
   always_comb
   begin
      next_state = state;
      case (state)
         ST_RUN:
         begin
            if (take)
            begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP:
         begin
            if (wake)
            begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE:
         begin
            if (settled)
            begin
               next_state = ST_RUN;
            end
         end
         default:
         begin
            next_state = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         state <= ST_RUN;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // Wake settle counter
   // ---------------------------------------------------------------
   // Counts only in the wake state, so two bits never wrap
   assign next_wake_cnt = waking ? wake_cnt + 2'h1 : 2'h0;

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         wake_cnt <= 2'h0;
      end
      else
      begin
         wake_cnt <= next_wake_cnt;
      end
   end

   // ---------------------------------------------------------------
   // Clock enables
   // ---------------------------------------------------------------
   // Core waits while the other domains restart
   always_comb
   begin
      wake_en      = CLK_EN_RESET;
      wake_en.core = 1'b0;
   end

   // Gating only removes clocks; no domain is reset, so contents survive
   always_comb
   begin
      next_en = CLOCK_ENABLE;
      case (next_state)
         ST_RUN:
         begin
            next_en = CLK_EN_RESET;
         end
         ST_SLEEP:
         begin
            next_en = sleep_en;
         end
         ST_WAKE:
         begin
            next_en = wake_en;
         end
         default:
         begin
            next_en = CLK_EN_RESET;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         CLOCK_ENABLE <= CLK_EN_RESET;
      end
      else
      begin
         CLOCK_ENABLE <= next_en;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // ASLEEP covers the wake state too, until the core clock returns
   assign ASLEEP      = ~running;
   assign ACTIVE_MODE = mode;
endmodule
`default_nettype wire

// ===== core/sleep_gate_map.sv
// Mode to clock-enable map used during sleep
`timescale 1ns/1ps
`default_nettype none
module sleep_gate_map
(
   input  wire logic [1:0]              mode,
   output wire sleep_ctrl_pkg::clk_en_t  en
);
   import sleep_ctrl_pkg::*;

   wire sleep_mode_t m = sleep_mode_t'(mode);
   wire is_idle = (m == MODE_IDLE);
   wire is_adc  = (m == MODE_ADC_QUIET);
   wire is_save = (m == MODE_PWR_SAVE);

   assign en.core      = 1'b0;
   assign en.memory    = is_idle;
   assign en.timers    = is_idle;
   assign en.serial    = is_idle;
   // Interrupt logic stays alive in every mode so wakeup remains possible
   assign en.irq       = 1'b1;
   assign en.adc       = is_adc;
   assign en.main_osc  = is_idle | is_adc;
   assign en.async_tmr = is_save | is_adc | is_idle;
endmodule
`default_nettype wire

// ===== include/sleep_ctrl_pkg.sv
// Package: sleep-mode clock gating constants and types
`default_nettype none
package sleep_ctrl_pkg;

   // ---------------------------------------------------------------
   // Mode encoding
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      MODE_IDLE      = 2'h0,
      MODE_ADC_QUIET = 2'h1,
      MODE_PWR_DOWN  = 2'h2,
      MODE_PWR_SAVE  = 2'h3
   } sleep_mode_t;

   // ---------------------------------------------------------------
   // Controller states, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_RUN   = 3'h1,
      ST_SLEEP = 3'h2,
      ST_WAKE  = 3'h4
   } sleep_state_t;

   // ---------------------------------------------------------------
   // Clock enables, one bit per gated domain
   // ---------------------------------------------------------------
   typedef struct packed
   {
      logic core;
      logic memory;
      logic timers;
      logic serial;
      logic irq;
      logic adc;
      logic main_osc;
      logic async_tmr;
   } clk_en_t;

   localparam clk_en_t CLK_EN_RESET = 8'hff;
   localparam logic [1:0] MODE_RESET = 2'h0;
   // Minimum time, in ns, the core clock stays off after wakeup so domains restart first
   localparam int WAKE_SETTLE_NS = 20;
   localparam int CLK_PERIOD_NS = 10;
   localparam logic [1:0] WAKE_CYCLES = 2'((WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage
`default_nettype wire

// ===== testbench/sleep_clock_props.sv
// Assertion checker for the sleep clock controller
`timescale 1ns/1ps
`default_nettype none
module sleep_clock_props
(
   input wire logic                    CLK,
   input wire logic                    RESET,
   input wire logic                    SLEEP_ENABLE,
   input wire logic [1:0]              MODE_SELECT,
   input wire logic                    SLEEP_REQUEST,
   input wire logic                    WAKE_IRQ,
   input wire sleep_ctrl_pkg::clk_en_t CLOCK_ENABLE,
   input wire logic                    ASLEEP,
   input wire logic [1:0]              ACTIVE_MODE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   property p_idle; $rose(ASLEEP) && ACTIVE_MODE == 2'h0 |-> CLOCK_ENABLE == 8'h7b; endproperty
   a_idle: assert property (p_idle) else $error("idle map");
   property p_adc; $rose(ASLEEP) && ACTIVE_MODE == 2'h1 |-> CLOCK_ENABLE == 8'h0f; endproperty
   a_adc: assert property (p_adc) else $error("adc map");
   property p_pd; $rose(ASLEEP) && ACTIVE_MODE == 2'h2 |-> CLOCK_ENABLE == 8'h08; endproperty
   a_pd: assert property (p_pd) else $error("power-down map");
   property p_ps; $rose(ASLEEP) && ACTIVE_MODE == 2'h3 |-> CLOCK_ENABLE == 8'h09; endproperty
   a_ps: assert property (p_ps) else $error("power-save map");
   // Irq must be quiet three edges so the synchroniser is known low
   property p_take; (!WAKE_IRQ)[*3] ##0 (SLEEP_ENABLE && SLEEP_REQUEST && !ASLEEP)
      |=> ASLEEP && ACTIVE_MODE == $past(MODE_SELECT); endproperty
   a_take: assert property (p_take) else $error("entry");
   property p_hold; ASLEEP && $past(ASLEEP) |-> $stable(ACTIVE_MODE); endproperty
   a_hold: assert property (p_hold) else $error("mode lost");
   property p_wake; ASLEEP && $rose(WAKE_IRQ) |-> ##[1:8] (!ASLEEP && CLOCK_ENABLE == 8'hff); endproperty
   a_wake: assert property (p_wake) else $error("wake");
endmodule
bind sleep_clock_ctrl sleep_clock_props u_props (.CLK, .RESET, .SLEEP_ENABLE, .MODE_SELECT, .SLEEP_REQUEST,
   .WAKE_IRQ, .CLOCK_ENABLE, .ASLEEP, .ACTIVE_MODE);
`default_nettype wire

// ===== testbench/tb.sv
// Testbench for the sleep clock controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sleep_ctrl_pkg::*;
   logic       CLK = 1'h0, RESET = 1'h1, SLEEP_ENABLE = 1'h0, SLEEP_REQUEST = 1'h0, WAKE_IRQ = 1'h0, ASLEEP;
   logic [1:0] MODE_SELECT = 2'h0, ACTIVE_MODE;
   clk_en_t    CLOCK_ENABLE;
   int         fails = 0, tests_run = 0;
   always #5 CLK = ~CLK;
   sleep_clock_ctrl uut (.CLK, .RESET, .SLEEP_ENABLE, .MODE_SELECT, .SLEEP_REQUEST, .WAKE_IRQ,
      .CLOCK_ENABLE, .ASLEEP, .ACTIVE_MODE);
   task cyc(input int n);
      repeat (n) @(negedge CLK);
   endtask
   task chk(input logic [8:0] e);
      tests_run++;
      if ({ASLEEP, CLOCK_ENABLE} !== e)
      begin
         fails++;
         $display("ERROR %0t got %h want %h", $time, {ASLEEP, CLOCK_ENABLE}, e);
      end
   endtask
   task chk_mode(input logic [1:0] e);
      tests_run++;
      if (ACTIVE_MODE !== e)
      begin
         fails++;
         $display("ERROR %0t mode got %h want %h", $time, ACTIVE_MODE, e);
      end
   endtask
   task enter(input logic [1:0] m, input logic [7:0] e);
      SLEEP_ENABLE = 1'h1;
      MODE_SELECT = m;
      SLEEP_REQUEST = 1'h1;
      cyc(1);
      SLEEP_REQUEST = 1'h0;
      MODE_SELECT = ~m;
      cyc(3);
      chk({1'h1, e});
      chk_mode(m);
   endtask
   task t_mode(input logic [1:0] m, input logic [7:0] e);
      int k;
      enter(m, e);
      WAKE_IRQ = 1'h1;
      for (k = 0; k < 20 && ASLEEP === 1'h1; k++)
         cyc(1);
      chk(9'h0ff);
      WAKE_IRQ = 1'h0;
      cyc(4);
      $display("mode %0d done", m);
   endtask
   task t_refuse;
      SLEEP_ENABLE = 1'h0;
      SLEEP_REQUEST = 1'h1;
      cyc(3);
      SLEEP_REQUEST = 1'h0;
      chk(9'h0ff);
      WAKE_IRQ = 1'h1;
      SLEEP_ENABLE = 1'h1;
      cyc(3);
      SLEEP_REQUEST = 1'h1;
      cyc(1);
      SLEEP_REQUEST = 1'h0;
      chk(9'h0ff);
      WAKE_IRQ = 1'h0;
      cyc(3);
      $display("refuse done");
   endtask
   // Hardware reset is the other way out of power-down
   task t_reset;
      enter(2'h2, 8'h08);
      RESET = 1'h1;
      cyc(1);
      chk(9'h0ff);
      RESET = 1'h0;
      cyc(2);
      chk_mode(MODE_RESET);
      $display("reset done");
   endtask
   task summarize;
      $display("%0d compares, %0d mismatches", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      cyc(16);
      RESET = 1'h0;
      cyc(1);
      chk(9'h0ff);
      t_mode(2'h0, 8'h7b);
      t_mode(2'h1, 8'h0f);
      t_mode(2'h2, 8'h08);
      t_mode(2'h3, 8'h09);
      t_refuse();
      t_reset();
      summarize();
   end
   // About five and a half times the expected run
   initial
   begin
      #5000;
      fails++;
      summarize();
   end
endmodule
`default_nettype wire
